// >>> design/pmx_pkg.sv
// Package with register map, field layouts, constants and state type of the wake sequencer
package pmx_pkg;

	// ****************************************
	// Register bus and map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
	localparam logic [7:0] OFF_OSC_TUNE = 8'h04;
	localparam logic [7:0] OFF_CONFIG = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_STATE = 8'h14;

	// ****************************************
	// Field layouts and reset values
	// ****************************************
	typedef struct packed {
		logic idle_en;
		logic [2:0] internal_freq_select;
		logic [2:0] rsvd;
		logic int_clk_sel;
	} pmx_osc_ctrl_t;

	typedef struct packed {
		logic [2:0] rsvd;
		logic [2:0] prim_mode;
		logic fail_safe_en;
		logic two_speed_en;
	} pmx_config_t;

	localparam logic [7:0] OSC_CTRL_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam int TRIM_W = 6;
	localparam logic [TRIM_W-1:0] TUNE_RST = 6'h00;

	// Primary source modes; crystal modes are the ones at or below MODE_HIGH_SPEED_CRYSTAL_PLL
	localparam logic [2:0] MODE_LOW_POWER_CRYSTAL = 3'h0;
	localparam logic [2:0] MODE_STANDARD_CRYSTAL = 3'h1;
	localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
	localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL_PLL = 3'h3;
	localparam logic [2:0] MODE_EXTERNAL_RESISTOR_CAP = 3'h4;
	localparam logic [2:0] MODE_EXTERNAL_CLOCK_INPUT = 3'h5;
	localparam logic [2:0] MODE_INTERNAL_OSC_WITH_IO = 3'h6;

	// ****************************************
	// Interrupt status bits
	// ****************************************
	localparam int IRQ_W = 5;
	localparam int IRQ_PRIM_READY = 0;
	localparam int IRQ_WDT_WAKE = 1;
	localparam int IRQ_WDT_RESET = 2;
	localparam int IRQ_INT_WAKE = 3;
	localparam int IRQ_CLK_FAIL = 4;

	// ****************************************
	// Vectors, calibration and timing
	// ****************************************
	localparam logic [15:0] VEC_HIGH = 16'h0008;
	localparam logic [15:0] VEC_LOW = 16'h0018;
	localparam logic [7:0] FACTORY_CAL_DEF = 8'h80;
	localparam int CLK_PERIOD_NS = 40;
	localparam int WAKE_DLY_NS = 10000;
	localparam int WAKE_DLY_CYC = (WAKE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W = 9;
	localparam int OST_W = 16;
	localparam int OST_CYC_DEF = 1024;

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_OST_WAIT,
		ST_RUN,
		ST_IDLE,
		ST_SLEEP,
		ST_WAKE_DLY,
		ST_WAKE_OST
	} pmx_state_t;

endpackage

// >>> design/pmx_wake_seq.sv
// Reset and power-managed mode exit sequencer with register port and interrupt
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps

module pmx_wake_seq #(
	parameter int OST_CYCLES = pmx_pkg::OST_CYC_DEF,
	parameter logic [7:0] FACTORY_CAL = pmx_pkg::FACTORY_CAL_DEF
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic rst_src_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic sleep_instr_i,
	input wire logic wdt_clear_instr_i,
	input wire logic wdt_timeout_i,
	input wire logic clk_fail_i,
	input wire logic irq_wake_i,
	input wire logic irq_high_i,
	input wire logic high_priority_global_irq_enable_i,
	input wire logic low_priority_global_irq_enable_i,
	output logic core_rst_o,
	output logic core_run_o,
	output logic prim_clk_en_o,
	output logic int_clk_sel_o,
	output logic [2:0] internal_freq_select_o,
	output logic [7:0] fast_osc_trim_o,
	output logic [7:0] slow_osc_trim_o,
	output logic wdt_clr_o,
	output logic wdt_rst_o,
	output logic vec_load_o,
	output logic [15:0] vector_o,
	output logic stack_push_o,
	output logic prim_ready_o,
	output logic irq_o
);

	// ****************************************
	// Registers
	// ****************************************
	pmx_pkg::pmx_state_t state_q, state_d;
	pmx_pkg::pmx_osc_ctrl_t ctrl_q;
	pmx_pkg::pmx_config_t cfg_q;
	logic [pmx_pkg::TRIM_W-1:0] tune_q;
	logic [pmx_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, irq_ev;
	logic [pmx_pkg::OST_W-1:0] ost_cnt_q;
	logic [pmx_pkg::DLY_W-1:0] dly_cnt_q;
	logic prim_en_q, prim_en_d, prim_ready_q, wake_irq_q, wdt_rst_q;
	logic [15:0] vec_q;
	logic [31:0] rdata_q;

	// ****************************************
	// Decode and next-state terms
	// ****************************************
	wire dev_rst = sys_rst_i | rst_src_i | wdt_rst_q;
	wire wr_ctrl = wr_i && (addr_i == pmx_pkg::OFF_OSC_CTRL);
	wire wr_tune = wr_i && (addr_i == pmx_pkg::OFF_OSC_TUNE);
	wire wr_cfg = wr_i && (addr_i == pmx_pkg::OFF_CONFIG);
	wire wr_stat = wr_i && (addr_i == pmx_pkg::OFF_IRQ_STAT);
	wire wr_mask = wr_i && (addr_i == pmx_pkg::OFF_IRQ_MASK);
	wire early_start = cfg_q.two_speed_en | cfg_q.fail_safe_en;
	// Only crystal sources need the start-up timer
	wire need_ost = cfg_q.prim_mode <= pmx_pkg::MODE_HIGH_SPEED_CRYSTAL_PLL;
	wire ost_done = ost_cnt_q == pmx_pkg::OST_W'(OST_CYCLES - 1);
	wire dly_done = dly_cnt_q == pmx_pkg::DLY_W'(pmx_pkg::WAKE_DLY_CYC - 1);
	wire run_sleep = (state_q == pmx_pkg::ST_RUN) && sleep_instr_i;
	// Primary idle keeps the crystal running, so its wake needs no timer
	wire prim_idle = ctrl_q.idle_en && !ctrl_q.int_clk_sel && prim_ready_q;
	wire in_pm = (state_q == pmx_pkg::ST_IDLE) || (state_q == pmx_pkg::ST_SLEEP);
	// Wake needs a time-out or the irq flags present; the core ORs the flags into irq_wake_i
	wire wake_ev = in_pm && (wdt_timeout_i || irq_wake_i);
	wire irq_vec = irq_wake_i && (high_priority_global_irq_enable_i || low_priority_global_irq_enable_i);
	wire wait_prim = !ctrl_q.int_clk_sel && !prim_ready_q && !early_start;
	wire go_run = (state_d == pmx_pkg::ST_RUN) && (state_q != pmx_pkg::ST_RUN);
	wire clk_fail_ev = clk_fail_i && cfg_q.fail_safe_en;
	// Frequency write while the internal block clocks the core restarts the watchdog
	wire ifs_clr = wr_ctrl && int_clk_sel_o;
	wire wdt_clr_d = run_sleep || wdt_clear_instr_i || clk_fail_ev || ifs_clr;
	wire [7:0] trim_sum = FACTORY_CAL + {{2{tune_q[pmx_pkg::TRIM_W-1]}}, tune_q};

	// Mode sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			pmx_pkg::ST_HOLD: state_d = early_start ? pmx_pkg::ST_RUN : pmx_pkg::ST_OST_WAIT;
			pmx_pkg::ST_OST_WAIT: if (prim_ready_q) state_d = pmx_pkg::ST_RUN;
			pmx_pkg::ST_RUN: begin
				if (run_sleep && !wdt_timeout_i) begin
					state_d = ctrl_q.idle_en ? pmx_pkg::ST_IDLE : pmx_pkg::ST_SLEEP;
				end
			end
			pmx_pkg::ST_IDLE, pmx_pkg::ST_SLEEP: if (wake_ev) state_d = pmx_pkg::ST_WAKE_DLY;
			pmx_pkg::ST_WAKE_DLY: begin
				if (dly_done) state_d = wait_prim ? pmx_pkg::ST_WAKE_OST : pmx_pkg::ST_RUN;
			end
			pmx_pkg::ST_WAKE_OST: if (prim_ready_q) state_d = pmx_pkg::ST_RUN;
			default: state_d = pmx_pkg::ST_HOLD;
		endcase
		if (dev_rst) state_d = pmx_pkg::ST_HOLD;
	end

	// Primary oscillator enable; sleep always stops it, idle only if not yet ready or the internal block is selected
	always_comb begin
		prim_en_d = prim_en_q;
		if (dev_rst || state_d == pmx_pkg::ST_WAKE_DLY) prim_en_d = 1'b1;
		else if (state_d == pmx_pkg::ST_SLEEP) prim_en_d = 1'b0;
		else if (state_d == pmx_pkg::ST_IDLE && (!prim_ready_q || !prim_idle)) prim_en_d = 1'b0;
	end

	// Sticky events: set wins over a write-one clear in the same cycle
	always_comb begin
		irq_ev = '0;
		irq_ev[pmx_pkg::IRQ_PRIM_READY] = prim_en_q && !prim_ready_q && (ost_done || !need_ost);
		irq_ev[pmx_pkg::IRQ_WDT_WAKE] = wake_ev && wdt_timeout_i;
		irq_ev[pmx_pkg::IRQ_WDT_RESET] = wdt_rst_q;
		irq_ev[pmx_pkg::IRQ_INT_WAKE] = wake_ev && irq_wake_i;
		irq_ev[pmx_pkg::IRQ_CLK_FAIL] = clk_fail_ev;
		stat_d = (stat_q & ~(wr_stat ? wdata_i[pmx_pkg::IRQ_W-1:0] : '0)) | irq_ev;
	end

	// Read mux, unmapped reads return zero
	always_comb begin
		rdata_q = '0;
		case (addr_i)
			pmx_pkg::OFF_OSC_CTRL: rdata_q = {24'h000000, ctrl_q};
			pmx_pkg::OFF_OSC_TUNE: rdata_q = {26'h0000000, tune_q};
			pmx_pkg::OFF_CONFIG: rdata_q = {24'h000000, cfg_q};
			pmx_pkg::OFF_IRQ_STAT: rdata_q = {27'h0000000, stat_q};
			pmx_pkg::OFF_IRQ_MASK: rdata_q = {27'h0000000, mask_q};
			pmx_pkg::OFF_STATE: rdata_q = {28'h0000000, prim_ready_q, state_q};
			default: rdata_q = '0;
		endcase
	end

	// ****************************************
	// Software registers
	// ****************************************
	// Control is cleared by every device reset, including watchdog reset
	always_ff @(posedge clk_i) begin
		if (dev_rst) ctrl_q <= pmx_pkg::OSC_CTRL_RST;
		else if (wr_ctrl) ctrl_q <= wdata_i[7:0];
	end

	// Configuration and trim survive device resets; only system reset clears them
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_q <= pmx_pkg::CONFIG_RST;
			tune_q <= pmx_pkg::TUNE_RST;
			mask_q <= '0;
			stat_q <= '0;
		end else begin
			if (wr_cfg) cfg_q <= wdata_i[7:0];
			if (wr_tune) tune_q <= wdata_i[pmx_pkg::TRIM_W-1:0];
			if (wr_mask) mask_q <= wdata_i[pmx_pkg::IRQ_W-1:0];
			stat_q <= stat_d;
		end
	end

	// ****************************************
	// Oscillator start-up timer and wake delay
	// ****************************************
	// Timer restarts whenever the primary source is stopped
	always_ff @(posedge clk_i) begin
		if (dev_rst || !prim_en_q) begin
			ost_cnt_q <= '0;
			prim_ready_q <= 1'b0;
		end else if (!prim_ready_q) begin
			ost_cnt_q <= ost_cnt_q + 1'b1;
			prim_ready_q <= ost_done || !need_ost;
		end
	end

	// Wake delay counts only inside its state
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || state_q != pmx_pkg::ST_WAKE_DLY) dly_cnt_q <= '0;
		else dly_cnt_q <= dly_cnt_q + 1'b1;
	end

	// ****************************************
	// State and outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= pmx_pkg::ST_HOLD;
			prim_en_q <= 1'b1;
			wdt_rst_q <= 1'b0;
			wake_irq_q <= 1'b0;
			vec_q <= pmx_pkg::VEC_HIGH;
		end else begin
			state_q <= state_d;
			prim_en_q <= prim_en_d;
			wdt_rst_q <= (state_q == pmx_pkg::ST_RUN) && wdt_timeout_i && !dev_rst;
			if (wake_ev) begin
				wake_irq_q <= irq_vec;
				vec_q <= irq_high_i ? pmx_pkg::VEC_HIGH : pmx_pkg::VEC_LOW;
			end
		end
	end

	// Registered outputs; run rises the edge after the delay ends
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			core_rst_o <= 1'b1;
			core_run_o <= 1'b0;
			prim_clk_en_o <= 1'b1;
			int_clk_sel_o <= 1'b1;
			internal_freq_select_o <= '0;
			fast_osc_trim_o <= FACTORY_CAL;
			slow_osc_trim_o <= FACTORY_CAL;
			wdt_clr_o <= 1'b0;
			wdt_rst_o <= 1'b0;
			vec_load_o <= 1'b0;
			stack_push_o <= 1'b0;
			vector_o <= pmx_pkg::VEC_HIGH;
			prim_ready_o <= 1'b0;
			irq_o <= 1'b0;
			rdata_o <= '0;
		end else begin
			core_rst_o <= state_d == pmx_pkg::ST_HOLD || state_d == pmx_pkg::ST_OST_WAIT;
			core_run_o <= state_d == pmx_pkg::ST_RUN;
			prim_clk_en_o <= prim_en_d;
			int_clk_sel_o <= ctrl_q.int_clk_sel || !prim_ready_q;
			internal_freq_select_o <= ctrl_q.internal_freq_select;
			fast_osc_trim_o <= trim_sum;
			slow_osc_trim_o <= trim_sum;
			wdt_clr_o <= wdt_clr_d;
			wdt_rst_o <= (state_q == pmx_pkg::ST_RUN) && wdt_timeout_i && !dev_rst;
			vec_load_o <= go_run && wake_irq_q && !dev_rst;
			stack_push_o <= go_run && wake_irq_q && !dev_rst;
			vector_o <= vec_q;
			prim_ready_o <= prim_ready_q;
			irq_o <= |(stat_d & mask_q);
			rdata_o <= rd_i ? rdata_q : '0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_ost_hold;
		(state_q == pmx_pkg::ST_OST_WAIT && !prim_ready_q) |=> core_rst_o && !core_run_o;
	endproperty
	a_ost_hold: assert property (p_ost_hold) else $error("core released before ready");

	property p_early_run;
		(state_q == pmx_pkg::ST_HOLD && !dev_rst && early_start) |=> core_run_o && !core_rst_o;
	endproperty
	a_early_run: assert property (p_early_run) else $error("two-speed start not taken");

	property p_ctrl_clear;
		wdt_rst_q |=> ctrl_q == pmx_pkg::OSC_CTRL_RST;
	endproperty
	a_ctrl_clear: assert property (p_ctrl_clear) else $error("control not cleared on reset");

	property p_sleep_stop;
		(run_sleep && !ctrl_q.idle_en && !wdt_timeout_i && !dev_rst) |=> !prim_clk_en_o;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("primary left on in sleep");

	property p_wdt_wake;
		(in_pm && wdt_timeout_i && !dev_rst) |=> state_q == pmx_pkg::ST_WAKE_DLY ##1 !wdt_rst_o;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog did not wake");

	property p_wdt_reset;
		(state_q == pmx_pkg::ST_RUN && wdt_timeout_i && !dev_rst) |=> wdt_rst_o ##1 core_rst_o;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");

	property p_wdt_clr;
		wdt_clear_instr_i |=> wdt_clr_o;
	endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");

	property p_wake_delay;
		$rose(state_q == pmx_pkg::ST_WAKE_DLY) |-> !core_run_o [*8] ##[1:300] core_run_o || core_rst_o;
	endproperty
	a_wake_delay: assert property (p_wake_delay) else $error("wake delay wrong");

	property p_resume;
		(state_q == pmx_pkg::ST_WAKE_DLY && dly_done && !wait_prim && !dev_rst) |=> core_run_o;
	endproperty
	a_resume: assert property (p_resume) else $error("resume late");

	property p_vector;
		vec_load_o |-> stack_push_o && (vector_o == pmx_pkg::VEC_HIGH || vector_o == pmx_pkg::VEC_LOW);
	endproperty
	a_vector: assert property (p_vector) else $error("vector or push wrong");

	// Written select reaches the oscillator mux two edges after the write
	property p_freq_sel;
		(wr_ctrl && !dev_rst) |=> ##1 internal_freq_select_o == $past(ctrl_q.internal_freq_select);
	endproperty
	a_freq_sel: assert property (p_freq_sel) else $error("frequency select not applied");

	property p_ifs_clr;
		(wr_ctrl && int_clk_sel_o) |=> wdt_clr_o;
	endproperty
	a_ifs_clr: assert property (p_ifs_clr) else $error("no clear on select write");

	// Primary idle must never stop a running primary source
	property p_prim_idle;
		(state_q == pmx_pkg::ST_IDLE && prim_idle && prim_en_q && !dev_rst) |=> prim_clk_en_o;
	endproperty
	a_prim_idle: assert property (p_prim_idle) else $error("primary stopped in idle");

	// Stable config only: a mode change in the last cycle has not reached the timer yet
	property p_skip_ost;
		(state_q == pmx_pkg::ST_WAKE_DLY && dly_done && !need_ost && $stable(cfg_q) && !dev_rst)
			|=> state_q == pmx_pkg::ST_RUN;
	endproperty
	a_skip_ost: assert property (p_skip_ost) else $error("start-up timer not skipped");

	property p_trim_cal;
		(tune_q == pmx_pkg::TUNE_RST) |=> fast_osc_trim_o == FACTORY_CAL && slow_osc_trim_o == FACTORY_CAL;
	endproperty
	a_trim_cal: assert property (p_trim_cal) else $error("calibration trim lost");

	property p_wake_flag;
		(in_pm && irq_wake_i && !dev_rst) |=> stat_q[pmx_pkg::IRQ_INT_WAKE];
	endproperty
	a_wake_flag: assert property (p_wake_flag) else $error("interrupt wake flag missing");

	c_irq_wake: cover property (state_q == pmx_pkg::ST_IDLE ##[1:400] vec_load_o);
	c_wdt_reset: cover property (wdt_rst_o);
	c_two_speed: cover property (core_run_o && !prim_ready_o);
	c_idle_wdt: cover property (state_q == pmx_pkg::ST_IDLE && wdt_timeout_i);

endmodule // pmx_wake_seq

// >>> tb/pmx_core_model.sv
// Behavioural core and clock-source model facing the wake sequencer
`timescale 1ns/1ps
module pmx_core_model (
	input wire logic clk_i,
	input wire logic [3:0] ev_i,
	input wire logic [3:0] irq_req_i,
	input wire logic wdt_clr_i,
	input wire logic wdt_rst_i,
	input wire logic vec_load_i,
	input wire logic [15:0] vector_i,
	input wire logic stack_push_i,
	output logic sleep_instr_o,
	output logic wdt_clear_instr_o,
	output logic wdt_timeout_o,
	output logic clk_fail_o,
	output logic irq_wake_o,
	output logic irq_high_o,
	output logic high_priority_global_irq_enable_o,
	output logic low_priority_global_irq_enable_o
);
	int clr_cnt = 0;
	int rst_cnt = 0;
	int push_cnt = 0;
	logic [15:0] pc = 16'h0000;

	// Event pulses from the instruction stream: sleep, clear, time-out, clock loss
	assign sleep_instr_o = ev_i[0];
	assign wdt_clear_instr_o = ev_i[1];
	assign wdt_timeout_o = ev_i[2];
	assign clk_fail_o = ev_i[3];

	// Flag summary, its priority and both global enables, as the core shows them
	assign irq_wake_o = irq_req_i[3];
	assign irq_high_o = irq_req_i[2];
	assign high_priority_global_irq_enable_o = irq_req_i[1];
	assign low_priority_global_irq_enable_o = irq_req_i[0];

	// Tally device answers; a push only counts beside a vector load
	always @(posedge clk_i) begin
		if (wdt_clr_i === 1'b1) clr_cnt <= clr_cnt + 1;
		if (wdt_rst_i === 1'b1) rst_cnt <= rst_cnt + 1;
		if (vec_load_i === 1'b1) begin
			pc <= vector_i;
			push_cnt <= push_cnt + ((stack_push_i === 1'b1) ? 1 : 0);
		end
	end
endmodule // pmx_core_model

// >>> tb/pmx_wake_seq_tb_top.sv
// Self-checking testbench for the wake sequencer
`timescale 1ns/1ps
module pmx_wake_seq_tb_top;
	localparam int OST = 40;
	logic clk_i, sys_rst_i, rst_src_i, wr_i, rd_i;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [3:0] ev_q, irq_q;
	logic core_rst_o, core_run_o, prim_clk_en_o, int_clk_sel_o, wdt_clr_o, wdt_rst_o;
	logic vec_load_o, stack_push_o, prim_ready_o, irq_o;
	logic sleep_w, clr_w, tmo_w, fail_w, irq_w, high_w, gh_w, gl_w;
	logic [2:0] internal_freq_select_o;
	logic [7:0] fast_osc_trim_o, slow_osc_trim_o;
	logic [15:0] vector_o;
	int mismatches = 0;
	int samples_checked = 0;
	int n, c;
	logic [2:0] hi_t = 3'b101, gh_t = 3'b001, gl_t = 3'b010;

	pmx_wake_seq #(.OST_CYCLES(OST)) u_pmx_wake_seq (.clk_i, .sys_rst_i, .rst_src_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_instr_i(sleep_w),
		.wdt_clear_instr_i(clr_w), .wdt_timeout_i(tmo_w), .clk_fail_i(fail_w),
		.irq_wake_i(irq_w), .irq_high_i(high_w), .high_priority_global_irq_enable_i(gh_w), .low_priority_global_irq_enable_i(gl_w), .core_rst_o,
		.core_run_o, .prim_clk_en_o, .int_clk_sel_o, .internal_freq_select_o,
		.fast_osc_trim_o, .slow_osc_trim_o, .wdt_clr_o, .wdt_rst_o, .vec_load_o, .vector_o,
		.stack_push_o, .prim_ready_o, .irq_o);

	pmx_core_model u_pmx_core_model (.clk_i, .ev_i(ev_q), .irq_req_i(irq_q),
		.wdt_clr_i(wdt_clr_o), .wdt_rst_i(wdt_rst_o),
		.vec_load_i(vec_load_o), .vector_i(vector_o), .stack_push_i(stack_push_o),
		.sleep_instr_o(sleep_w), .wdt_clear_instr_o(clr_w), .wdt_timeout_o(tmo_w),
		.clk_fail_o(fail_w), .irq_wake_o(irq_w), .irq_high_o(high_w), .high_priority_global_irq_enable_o(gh_w),
		.low_priority_global_irq_enable_o(gl_w));

	// ****************************************
	// Clock, shared tasks and watchdog
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= {24'h000000, v};
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk("register", exp, rdata_o);
	endtask

	// Bounded wait for execution; n counts edges seen
	task automatic wait_run();
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (core_run_o !== 1'b1 && n < 2000);
		chk("core running", 32'h1, {31'h0, core_run_o});
	endtask

	// One-cycle core event: 0 sleep, 1 watchdog clear, 2 time-out, 3 clock loss
	task automatic fire(input int which);
		@(posedge clk_i);
		ev_q <= 4'h1 << which;
		@(posedge clk_i);
		ev_q <= 4'h0;
	endtask

	// Interrupt level, priority and global enables, held until changed
	task automatic set_irq(input logic w, input logic h, input logic gh, input logic gl);
		@(posedge clk_i);
		irq_q <= {w, h, gh, gl};
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#(40 * 10000);
		mismatches++;
		wrap_up();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		sys_rst_i = 1'b1;
		rst_src_i = 1'b0;
		{wr_i, rd_i, addr_i, wdata_i, ev_q, irq_q} = '0;
		repeat (6) @(posedge clk_i);
		chk("fast trim", 32'h80, {24'h0, fast_osc_trim_o});
		sys_rst_i <= 1'b0;
		rdck(pmx_pkg::OFF_OSC_CTRL, 32'h0);
		rdck(pmx_pkg::OFF_STATE, 32'h1);
		chk("core held", 32'h1, {31'h0, core_rst_o});
		wait_run();
		chk("start-up length", 32'h1, {31'h0, n >= OST - 4});
		chk("ready flag", 32'h1, {31'h0, prim_ready_o});
		rdck(pmx_pkg::OFF_IRQ_STAT, 32'h1);
		chk("masked irq", 32'h0, {31'h0, irq_o});
		wr(pmx_pkg::OFF_IRQ_MASK, 8'h1 << pmx_pkg::IRQ_WDT_RESET);
		rdck(8'h20, 32'h0);
		wr(pmx_pkg::OFF_STATE, 8'h00);
		rdck(pmx_pkg::OFF_STATE, 32'ha);
		wr(pmx_pkg::OFF_CONFIG, 8'h14);
		// Select the internal block first: with the primary ready, only then does a select write clear the watchdog
		wr(pmx_pkg::OFF_OSC_CTRL, 8'h01);
		c = u_pmx_core_model.clr_cnt;
		wr(pmx_pkg::OFF_OSC_CTRL, 8'h51);
		repeat (2) @(posedge clk_i);
		chk("freq select", 32'h5, {29'h0, internal_freq_select_o});
		chk("clear on freq", c + 1, u_pmx_core_model.clr_cnt);
		wr(pmx_pkg::OFF_OSC_TUNE, 8'h3f);
		repeat (2) @(posedge clk_i);
		chk("fast trim", 32'h7f, {24'h0, fast_osc_trim_o});
		chk("slow trim", 32'h7f, {24'h0, slow_osc_trim_o});
		// Sleep, then a watchdog time-out wakes after the fixed delay
		fire(0);
		repeat (2) @(posedge clk_i);
		chk("clear on sleep", c + 2, u_pmx_core_model.clr_cnt);
		rdck(pmx_pkg::OFF_STATE, 32'h4);
		fire(2);
		wait_run();
		chk("wake delay", 32'h1, {31'h0, n >= pmx_pkg::WAKE_DLY_CYC && n <= pmx_pkg::WAKE_DLY_CYC + 2});
		rdck(pmx_pkg::OFF_IRQ_STAT, 32'h3);
		wr(pmx_pkg::OFF_IRQ_STAT, 8'h03);
		fire(1);
		repeat (2) @(posedge clk_i);
		chk("clear instr", c + 3, u_pmx_core_model.clr_cnt);
		// Interrupt wakes from primary idle: high, low, and with enables off
		wr(pmx_pkg::OFF_OSC_CTRL, 8'h80);
		for (int i = 0; i < 3; i++) begin
			fire(0);
			rdck(pmx_pkg::OFF_STATE, 32'hb);
			set_irq(1'b1, hi_t[i], gh_t[i], gl_t[i]);
			wait_run();
			repeat (2) @(posedge clk_i);
			chk("vector", (i == 0) ? pmx_pkg::VEC_HIGH : pmx_pkg::VEC_LOW, u_pmx_core_model.pc);
			chk("pushes", (i == 0) ? 1 : 2, u_pmx_core_model.push_cnt);
			set_irq(1'b0, 1'b0, 1'b0, 1'b0);
			rdck(pmx_pkg::OFF_IRQ_STAT, 32'h8);
			wr(pmx_pkg::OFF_IRQ_STAT, 8'h08);
		end
		// Watchdog time-out while running resets the device
		fire(2);
		repeat (3) @(posedge clk_i);
		chk("wdt reset", 32'h1, u_pmx_core_model.rst_cnt);
		chk("irq level", 32'h1, {31'h0, irq_o});
		rdck(pmx_pkg::OFF_OSC_CTRL, 32'h0);
		rdck(pmx_pkg::OFF_CONFIG, 32'h14);
		wr(pmx_pkg::OFF_IRQ_STAT, 8'h04);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		wait_run();
		// Two-speed start on a crystal, clock loss, sleep before ready
		wr(pmx_pkg::OFF_CONFIG, 8'h03);
		@(posedge clk_i);
		rst_src_i <= 1'b1;
		@(posedge clk_i);
		rst_src_i <= 1'b0;
		wait_run();
		chk("early start", 32'h0, {31'h0, prim_ready_o});
		chk("internal clock", 32'h1, {31'h0, int_clk_sel_o});
		c = u_pmx_core_model.clr_cnt;
		fire(3);
		repeat (2) @(posedge clk_i);
		chk("clear on loss", c + 1, u_pmx_core_model.clr_cnt);
		fire(0);
		repeat (2) @(posedge clk_i);
		chk("primary off", 32'h0, {31'h0, prim_clk_en_o});
		fire(2);
		wait_run();
		wrap_up();
	end
endmodule // pmx_wake_seq_tb_top
